// >>> fpes_pkg.sv
package fpes_pkg;

  // Flash command codes
  localparam logic [7:0] FPES_CMD_READ_ARRAY = 8'hFF;
  localparam logic [7:0] FPES_CMD_CONFIRM = 8'hD0;
  localparam logic [7:0] FPES_CMD_PROG = 8'h40;
  localparam logic [7:0] FPES_CMD_PROG_ALT = 8'h10;
  localparam logic [7:0] FPES_CMD_BUF_PROG = 8'hE8;
  localparam logic [7:0] FPES_CMD_ERASE_SETUP = 8'h20;
  localparam logic [7:0] FPES_CMD_CHIP_SETUP = 8'h30;
  localparam logic [7:0] FPES_CMD_CLR_STATUS = 8'h50;

  // Largest transfer count minus one per bus width
  localparam logic [7:0] FPES_CNT_MAX_BYTE = 8'h1F;
  localparam logic [7:0] FPES_CNT_MAX_WORD = 8'h0F;

  // Flash status and extended status bit positions
  localparam int FPES_ST_READY = 7;
  localparam int FPES_ST_ERASE_ERR = 5;
  localparam int FPES_ST_PROG_ERR = 4;
  localparam int FPES_ST_SUPPLY_ERR = 3;
  localparam int FPES_ST_LOCK_ERR = 1;
  localparam int FPES_XST_BUF_AVAIL = 7;

  // Register byte offsets
  localparam logic [11:0] FPES_REG_CTRL = 12'h000;
  localparam logic [11:0] FPES_REG_ADDR = 12'h004;
  localparam logic [11:0] FPES_REG_DATA = 12'h008;
  localparam logic [11:0] FPES_REG_COUNT = 12'h00C;
  localparam logic [11:0] FPES_REG_STATUS = 12'h010;
  localparam logic [11:0] FPES_REG_RDATA = 12'h014;
  localparam logic [11:0] FPES_BUF_BASE = 12'h080;
  localparam logic [11:0] FPES_BUF_LAST = 12'h0FC;
  localparam int FPES_BUF_IDX_LSB = 2;

  // Control register fields
  localparam int FPES_CTRL_START = 0;
  localparam int FPES_CTRL_OP_LSB = 1;
  localparam int FPES_CTRL_OP_W = 3;
  localparam int FPES_CTRL_BYTE = 4;
  localparam int FPES_CTRL_WP_HIGH = 5;
  localparam int FPES_CTRL_ALT = 6;

  // Status register fields
  localparam int FPES_STS_BUSY = 0;
  localparam int FPES_STS_DONE = 1;
  localparam int FPES_STS_ERR = 2;
  localparam int FPES_STS_REFUSED = 3;
  localparam int FPES_STS_PIN = 4;
  localparam int FPES_STS_FLASH_LSB = 8;

  typedef enum logic [2:0] {
    FPES_OP_BLOCK_ERASE = 3'h0,
    FPES_OP_CHIP_ERASE = 3'h1,
    FPES_OP_WORD_PROG = 3'h2,
    FPES_OP_BUF_PROG = 3'h3,
    FPES_OP_CLR_STATUS = 3'h4,
    FPES_OP_READ_ARRAY = 3'h5
  } fpes_op_e;

  // Flash bus timing
  localparam int FPES_CLK_NS = 8;
  localparam int FPES_T_WE_LOW_NS = 50;
  localparam int FPES_T_WE_HIGH_NS = 30;
  localparam int FPES_T_READ_NS = 100;
  localparam int FPES_WE_LOW_CYC = (FPES_T_WE_LOW_NS + FPES_CLK_NS - 1) / FPES_CLK_NS;
  localparam int FPES_WE_HIGH_CYC = (FPES_T_WE_HIGH_NS + FPES_CLK_NS - 1) / FPES_CLK_NS;
  localparam int FPES_READ_CYC = (FPES_T_READ_NS + FPES_CLK_NS - 1) / FPES_CLK_NS;
  localparam logic [7:0] FPES_WE_LOW_LOAD = 8'(FPES_WE_LOW_CYC - 1);
  localparam logic [7:0] FPES_WE_HIGH_LOAD = 8'(FPES_WE_HIGH_CYC - 1);
  localparam logic [7:0] FPES_READ_LOAD = 8'(FPES_READ_CYC - 1);

endpackage : fpes_pkg

// >>> fpes_buf_mem.sv
`timescale 1ns/1ps
module fpes_buf_mem #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32
) (
  // Clock
  input wire logic clk,
  input wire logic clk_en,
  // Write port
  input wire logic wr_en,
  input wire logic [$clog2(DEPTH)-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  // Read port
  input wire logic [$clog2(DEPTH)-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);

  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clk) begin
    if (clk_en && wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // Registered read keeps the flash data path free of a long mux
  always_ff @(posedge clk) begin
    if (clk_en) begin
      rd_data <= mem[rd_addr];
    end
  end

endmodule : fpes_buf_mem

// >>> fpes_host.sv
// Function
// - Block erase is a setup write then confirm, both at an address in the block.
// - Word program is setup 40H or 10H, then one address and data write.
// - Buffered setup returns extended status; retry setup until buffer available.
// - Next write is count minus one, within byte or word limit.
// - Data writes start at start address within range, then confirm.
// - Buffered program refused while program or erase error bit is set.
`timescale 1ns/1ps
module fpes_host #(
  parameter int ADDR_W = 21,
  parameter int BUF_DEPTH = 32
) (
  // Clock and reset
  input wire logic clk,
  input wire logic clk_en,
  input wire logic sys_rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Flash pins
  output logic [ADDR_W-1:0] fl_addr,
  output logic [15:0] fl_dq_o,
  output logic fl_dq_oe,
  input wire logic [15:0] fl_dq_i,
  output logic fl_ce_n,
  output logic fl_oe_n,
  output logic fl_we_n,
  output logic fl_byte_n,
  output logic fl_wp_n,
  input wire logic fl_ready_busy
);
  import fpes_pkg::*;

  localparam int IDX_W = $clog2(BUF_DEPTH);

  generate
    if (ADDR_W < 16 || ADDR_W > 32 || BUF_DEPTH < 32 || BUF_DEPTH > 256) begin : g_bad_param
      $error("fpes_host: unsupported ADDR_W or BUF_DEPTH");
    end
  endgenerate

  typedef enum logic [7:0] {
    S_IDLE = 8'h01,
    S_SETUP = 8'h02,
    S_XSR = 8'h04,
    S_COUNT = 8'h08,
    S_LOAD = 8'h10,
    S_CONFIRM = 8'h20,
    S_POLL = 8'h40,
    S_READ = 8'h80
  } fpes_state_e;

  typedef enum logic [2:0] {
    B_IDLE = 3'b001,
    B_STROBE = 3'b010,
    B_RECOVER = 3'b100
  } fpes_bus_e;

  fpes_state_e state;
  fpes_bus_e bstate;
  fpes_op_e op;
  logic [ADDR_W-1:0] tgt_addr;
  logic [15:0] data_reg;
  logic [7:0] count;
  logic alt_code;
  logic busy;
  logic done;
  logic err;
  logic refused;
  logic [7:0] flash_status;
  logic [15:0] rdata;
  logic [IDX_W-1:0] idx;
  logic [7:0] btimer;
  logic cyc_go;
  logic cyc_done;
  logic [15:0] cyc_rdata;
  logic cyc_wr;
  logic [ADDR_W-1:0] cyc_addr;
  logic [15:0] cyc_data;
  logic [7:0] setup_code;
  logic [15:0] mem_rdata;
  logic [31:0] status_word;
  logic apb_acc;
  logic apb_wr;
  logic buf_hit;
  logic start_req;
  logic [7:0] cnt_max;
  logic start_bad;

  assign apb_acc = psel && penable && !pready;
  assign apb_wr = apb_acc && pwrite;
  assign buf_hit = (paddr >= FPES_BUF_BASE) && (paddr <= FPES_BUF_LAST) && (paddr[1:0] == 2'h0);
  assign start_req = apb_wr && (paddr == FPES_REG_CTRL) && pwdata[FPES_CTRL_START] && !busy;
  assign cnt_max = pwdata[FPES_CTRL_BYTE] ? FPES_CNT_MAX_BYTE : FPES_CNT_MAX_WORD;

  // Bad start: unknown op, buffer program with stale errors or oversize count
  always_comb begin
    start_bad = 1'b0;
    if (pwdata[FPES_CTRL_OP_LSB +: FPES_CTRL_OP_W] > FPES_OP_READ_ARRAY) begin
      start_bad = 1'b1;
    end else if (pwdata[FPES_CTRL_OP_LSB +: FPES_CTRL_OP_W] == FPES_OP_BUF_PROG) begin
      start_bad = flash_status[FPES_ST_PROG_ERR] || flash_status[FPES_ST_ERASE_ERR]
                  || (count > cnt_max);
    end
  end

  fpes_buf_mem #(
    .WIDTH(16),
    .DEPTH(BUF_DEPTH)
  ) u_buf (
    .clk(clk),
    .clk_en(clk_en),
    .wr_en(apb_wr && buf_hit),
    .wr_addr(paddr[FPES_BUF_IDX_LSB +: IDX_W]),
    .wr_data(pwdata[15:0]),
    .rd_addr(idx),
    .rd_data(mem_rdata)
  );

  always_comb begin
    status_word = 32'h0;
    status_word[FPES_STS_BUSY] = busy;
    status_word[FPES_STS_DONE] = done;
    status_word[FPES_STS_ERR] = err;
    status_word[FPES_STS_REFUSED] = refused;
    status_word[FPES_STS_PIN] = fl_ready_busy;
    status_word[FPES_STS_FLASH_LSB +: 8] = flash_status;
  end

  // APB slave answers one cycle into the access phase
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else if (clk_en) begin
      pready <= apb_acc;
      pslverr <= 1'b0;
      prdata <= 32'h0;
      if (apb_acc) begin
        if (paddr == FPES_REG_CTRL) begin
          prdata[FPES_CTRL_OP_LSB +: FPES_CTRL_OP_W] <= op;
          prdata[FPES_CTRL_BYTE] <= !fl_byte_n;
          prdata[FPES_CTRL_WP_HIGH] <= fl_wp_n;
          prdata[FPES_CTRL_ALT] <= alt_code;
        end else if (paddr == FPES_REG_ADDR) begin
          prdata <= 32'(tgt_addr);
        end else if (paddr == FPES_REG_DATA) begin
          prdata <= 32'(data_reg);
        end else if (paddr == FPES_REG_COUNT) begin
          prdata <= 32'(count);
        end else if (paddr == FPES_REG_STATUS) begin
          prdata <= status_word;
        end else if (paddr == FPES_REG_RDATA) begin
          prdata <= 32'(rdata);
        end else if (!buf_hit) begin
          pslverr <= 1'b1;
        end
      end
    end
  end

  // Configuration registers; locked while a sequence runs
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tgt_addr <= '0;
      data_reg <= 16'h0;
      count <= 8'h0;
      op <= FPES_OP_BLOCK_ERASE;
      fl_byte_n <= 1'b1;
      fl_wp_n <= 1'b0;
      alt_code <= 1'b0;
    end else if (clk_en && apb_wr && !busy) begin
      if (paddr == FPES_REG_CTRL) begin
        op <= fpes_op_e'(pwdata[FPES_CTRL_OP_LSB +: FPES_CTRL_OP_W]);
        fl_byte_n <= !pwdata[FPES_CTRL_BYTE];
        fl_wp_n <= pwdata[FPES_CTRL_WP_HIGH];
        alt_code <= pwdata[FPES_CTRL_ALT];
      end else if (paddr == FPES_REG_ADDR) begin
        tgt_addr <= pwdata[ADDR_W-1:0];
      end else if (paddr == FPES_REG_DATA) begin
        data_reg <= pwdata[15:0];
      end else if (paddr == FPES_REG_COUNT) begin
        count <= pwdata[7:0];
      end
    end
  end

  always_comb begin
    case (op)
      FPES_OP_BLOCK_ERASE: setup_code = FPES_CMD_ERASE_SETUP;
      FPES_OP_CHIP_ERASE: setup_code = FPES_CMD_CHIP_SETUP;
      FPES_OP_WORD_PROG: setup_code = alt_code ? FPES_CMD_PROG_ALT : FPES_CMD_PROG;
      FPES_OP_BUF_PROG: setup_code = FPES_CMD_BUF_PROG;
      FPES_OP_CLR_STATUS: setup_code = FPES_CMD_CLR_STATUS;
      default: setup_code = FPES_CMD_READ_ARRAY;
    endcase
  end

  // Flash cycle chosen by sequencer state
  always_comb begin
    cyc_wr = 1'b1;
    cyc_addr = tgt_addr;
    cyc_data = 16'(setup_code);
    case (state)
      S_XSR: cyc_wr = 1'b0;
      S_COUNT: cyc_data = 16'(count);
      S_LOAD: begin
        if (op == FPES_OP_BUF_PROG) begin
          cyc_addr = ADDR_W'(tgt_addr + ADDR_W'(idx));
          cyc_data = mem_rdata;
        end else begin
          cyc_data = data_reg;
        end
      end
      S_CONFIRM: cyc_data = 16'(FPES_CMD_CONFIRM);
      S_POLL: cyc_wr = 1'b0;
      S_READ: cyc_wr = 1'b0;
      default: cyc_wr = 1'b1;
    endcase
  end

  // Sequencer
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state <= S_IDLE;
      busy <= 1'b0;
      done <= 1'b0;
      err <= 1'b0;
      refused <= 1'b0;
      flash_status <= 8'h0;
      rdata <= 16'h0;
      idx <= '0;
      cyc_go <= 1'b0;
    end else if (clk_en) begin
      cyc_go <= 1'b0;
      if (state == S_IDLE) begin
        if (start_req) begin
          done <= start_bad;
          refused <= start_bad;
          err <= 1'b0;
          if (!start_bad) begin
            busy <= 1'b1;
            state <= S_SETUP;
          end
        end
      end else if (cyc_done) begin
        case (state)
          S_SETUP: begin
            if (op == FPES_OP_BLOCK_ERASE || op == FPES_OP_CHIP_ERASE) begin
              state <= S_CONFIRM;
            end else if (op == FPES_OP_WORD_PROG) begin
              state <= S_LOAD;
            end else if (op == FPES_OP_BUF_PROG) begin
              state <= S_XSR;
            end else if (op == FPES_OP_READ_ARRAY) begin
              state <= S_READ;
            end else begin
              flash_status <= 8'h0;
              busy <= 1'b0;
              done <= 1'b1;
              state <= S_IDLE;
            end
          end
          S_XSR: begin
            // Setup is dropped by the device when no buffer is free
            state <= cyc_rdata[FPES_XST_BUF_AVAIL] ? S_COUNT : S_SETUP;
          end
          S_COUNT: begin
            idx <= '0;
            state <= S_LOAD;
          end
          S_LOAD: begin
            if (op != FPES_OP_BUF_PROG) begin
              state <= S_POLL;
            end else if (idx == count[IDX_W-1:0]) begin
              state <= S_CONFIRM;
            end else begin
              idx <= idx + 1'b1;
            end
          end
          S_CONFIRM: state <= S_POLL;
          S_POLL: begin
            // Reads give status without a command until finished
            if (cyc_rdata[FPES_ST_READY]) begin
              flash_status <= cyc_rdata[7:0];
              err <= cyc_rdata[FPES_ST_ERASE_ERR] || cyc_rdata[FPES_ST_PROG_ERR]
                     || cyc_rdata[FPES_ST_SUPPLY_ERR] || cyc_rdata[FPES_ST_LOCK_ERR];
              busy <= 1'b0;
              done <= 1'b1;
              state <= S_IDLE;
            end
          end
          default: begin
            rdata <= cyc_rdata;
            busy <= 1'b0;
            done <= 1'b1;
            state <= S_IDLE;
          end
        endcase
      end else if (bstate == B_IDLE && !cyc_go) begin
        cyc_go <= 1'b1;
      end
    end
  end

  // Flash bus cycle engine; data stays driven through recovery so the
  // rising write strobe latches stable address and data
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      bstate <= B_IDLE;
      btimer <= 8'h0;
      fl_addr <= '0;
      fl_dq_o <= 16'h0;
      fl_dq_oe <= 1'b0;
      fl_ce_n <= 1'b1;
      fl_oe_n <= 1'b1;
      fl_we_n <= 1'b1;
      cyc_done <= 1'b0;
      cyc_rdata <= 16'h0;
    end else if (clk_en) begin
      cyc_done <= 1'b0;
      case (bstate)
        B_IDLE: begin
          if (cyc_go) begin
            fl_addr <= cyc_addr;
            fl_ce_n <= 1'b0;
            if (cyc_wr) begin
              fl_we_n <= 1'b0;
              fl_dq_oe <= 1'b1;
              fl_dq_o <= cyc_data;
              btimer <= FPES_WE_LOW_LOAD;
            end else begin
              fl_oe_n <= 1'b0;
              btimer <= FPES_READ_LOAD;
            end
            bstate <= B_STROBE;
          end
        end
        B_STROBE: begin
          if (btimer != 8'h0) begin
            btimer <= btimer - 8'h01;
          end else begin
            if (!fl_oe_n) begin
              cyc_rdata <= fl_dq_i;
            end
            fl_we_n <= 1'b1;
            fl_oe_n <= 1'b1;
            btimer <= FPES_WE_HIGH_LOAD;
            bstate <= B_RECOVER;
          end
        end
        default: begin
          if (btimer != 8'h0) begin
            btimer <= btimer - 8'h01;
          end else begin
            fl_ce_n <= 1'b1;
            fl_dq_oe <= 1'b0;
            cyc_done <= 1'b1;
            bstate <= B_IDLE;
          end
        end
      endcase
    end
  end

endmodule : fpes_host

// >>> fpes_host_assertions.sv
`timescale 1ns/1ps
module fpes_host_assertions #(
  parameter int ADDR_W = 21,
  parameter int BUF_DEPTH = 32
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Flash pins
  input wire logic [ADDR_W-1:0] fl_addr,
  input wire logic [15:0] fl_dq_o,
  input wire logic fl_dq_oe,
  input wire logic fl_ce_n,
  input wire logic fl_oe_n,
  input wire logic fl_we_n
);
  default clocking dc @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_pready_answer: assert property (psel && penable && !pready |=> pready)
    else $error("pready late");
  a_pready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_slverr_pair: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_rdata_quiet: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata not zero outside answer");
  a_strobe_in_ce: assert property (!fl_we_n |-> !fl_ce_n && fl_dq_oe && fl_oe_n)
    else $error("write strobe outside a driven write cycle");
  a_we_width: assert property ($fell(fl_we_n) |-> !fl_we_n [*7] ##1 fl_we_n)
    else $error("write strobe width wrong");
  a_data_hold: assert property ($rose(fl_we_n) |->
    $stable(fl_dq_o) && $stable(fl_addr) ##1 $stable(fl_dq_o) [*3])
    else $error("address or data moved around strobe rise");
  a_read_width: assert property ($fell(fl_oe_n) |-> !fl_ce_n throughout (!fl_oe_n [*8]))
    else $error("status read too short");
  a_read_no_drive: assert property (!fl_oe_n |-> !fl_dq_oe)
    else $error("bus driven during read");

  c_write: cover property ($rose(fl_we_n));
  c_read: cover property ($rose(fl_oe_n));
  c_slverr: cover property (pslverr);
endmodule : fpes_host_assertions

bind fpes_host fpes_host_assertions #(.ADDR_W(ADDR_W), .BUF_DEPTH(BUF_DEPTH)) chk_i (
  .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .fl_addr(fl_addr), .fl_dq_o(fl_dq_o),
  .fl_dq_oe(fl_dq_oe), .fl_ce_n(fl_ce_n), .fl_oe_n(fl_oe_n), .fl_we_n(fl_we_n));

// >>> fpes_flash_model.sv
`timescale 1ns/1ps
module fpes_flash_model #(
  parameter int BUSY_NS = 400
) (
  // Flash pins
  input wire logic clk,
  input wire logic [20:0] fl_addr,
  input wire logic [15:0] fl_dq_o,
  input wire logic fl_ce_n,
  input wire logic fl_oe_n,
  input wire logic fl_we_n,
  input wire logic fl_wp_n,
  output logic [15:0] fl_dq_i,
  output logic fl_ready_busy,
  // Supply condition
  input wire logic vpp_low,
  // Blocks whose erase fails during a chip erase
  input wire logic [3:0] erase_fail
);
  // Four blocks of 16 words, block 1 locked
  logic [15:0] mem [64];
  logic [15:0] bufr [16];
  logic [7:0] sr;
  logic [1:0] mode;
  logic [5:0] a;
  logic [5:0] base;
  logic [15:0] d;
  logic [3:0] lock;
  int pend;
  int cnt;
  int idx;
  realtime busy_until;

  function automatic logic bad(input logic [5:0] x, input int code, input logic uselock);
    if (vpp_low) sr[3] = 1'b1;
    else if (uselock && lock[x[5:4]] && !fl_wp_n) sr[1] = 1'b1;
    else return 1'b0;
    sr[code] = 1'b1;
    return 1'b1;
  endfunction : bad

  initial begin
    foreach (mem[i]) mem[i] = 16'hFFFF;
    sr = 8'h00;
    mode = 2'd0;
    pend = 0;
    lock = 4'h2;
    busy_until = 0;
    fl_dq_i = 16'h0000;
    fl_ready_busy = 1'b1;
  end

  always @(posedge fl_we_n) if (!fl_ce_n) begin
    a = fl_addr[5:0];
    d = fl_dq_o;
    case (pend)
      0: begin
        mode = 2'd1;
        case (d[7:0])
          8'hFF: mode = 2'd0;
          8'h20: pend = 1;
          8'h30: pend = 2;
          8'h40, 8'h10: pend = 3;
          8'h50: sr = 8'h00;
          8'hE8: begin
            mode = 2'd2;
            if (!(sr[4] | sr[5])) pend = 4;
          end
          // Suspend codes land here, so an erase is never paused
          default: ;
        endcase
      end
      1, 2: begin
        if (d[7:0] != 8'hD0) sr[5:4] = 2'b11;
        else if (!bad(a, 5, pend == 1)) begin
          busy_until = $realtime + BUSY_NS;
          for (int b = 0; b < 4; b++)
            if ((pend == 2 && (!lock[b] || fl_wp_n)) || (pend == 1 && b == a[5:4])) begin
              // Failing block ends the chip erase, later blocks untouched
              if (pend == 2 && erase_fail[b]) begin
                sr[5] = 1'b1;
                break;
              end
              for (int i = 0; i < 16; i++) mem[b * 16 + i] = 16'hFFFF;
            end
        end
        pend = 0;
      end
      3: begin
        // Only clears bits, so verify never flags a mismatch
        if (!bad(a, 4, 1'b1)) begin
          mem[a] = mem[a] & d;
          busy_until = $realtime + BUSY_NS;
        end
        pend = 0;
      end
      4: begin
        cnt = d[7:0];
        base = a;
        idx = 0;
        mode = 2'd1;
        pend = 5;
      end
      5: begin
        bufr[idx[3:0]] = d;
        idx++;
        if (idx > cnt) pend = 6;
      end
      default: begin
        if (d[7:0] != 8'hD0) sr[5:4] = 2'b11;
        else if (!bad(base, 4, 1'b1)) begin
          busy_until = $realtime + BUSY_NS;
          for (int i = 0; i <= cnt; i++) begin
            if (((base + i) >> 4) != (base >> 4)) begin
              sr[5:4] = 2'b11;
              break;
            end
            mem[base + i] = mem[base + i] & bufr[i];
          end
        end
        pend = 0;
      end
    endcase
  end

  // Released bus toggles so a stale value never passes
  always @(posedge clk) begin
    fl_ready_busy <= ($realtime >= busy_until);
    if (!fl_ce_n && !fl_oe_n)
      fl_dq_i <= (mode == 2'd0) ? mem[fl_addr[5:0]] :
        (mode == 2'd2) ? {8'h00, !(sr[4] | sr[5]), 7'h00} :
        {8'h00, ($realtime >= busy_until), sr[6:0]};
    else
      fl_dq_i <= ~fl_dq_i;
  end
endmodule : fpes_flash_model

// >>> fpes_host_bench.sv
`timescale 1ns/1ps
module fpes_host_bench;
  import fpes_pkg::*;
  logic clk, clk_en, sys_rst, psel, penable, pwrite, pready, pslverr, vpp_low, er;
  logic [3:0] erase_fail;
  logic [23:0] snap;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [20:0] fl_addr;
  logic [15:0] fl_dq_o, fl_dq_i;
  logic fl_dq_oe, fl_ce_n, fl_oe_n, fl_we_n, fl_byte_n, fl_wp_n, fl_ready_busy;
  logic [7:0] vexp [4] = '{8'hA8, 8'hA8, 8'h98, 8'h98};
  int n_fail = 0;
  int check_count = 0;

  fpes_host #(.ADDR_W(21), .BUF_DEPTH(32)) dut (.clk(clk), .clk_en(clk_en),
    .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fl_addr(fl_addr), .fl_dq_o(fl_dq_o), .fl_dq_oe(fl_dq_oe), .fl_dq_i(fl_dq_i),
    .fl_ce_n(fl_ce_n), .fl_oe_n(fl_oe_n), .fl_we_n(fl_we_n), .fl_byte_n(fl_byte_n),
    .fl_wp_n(fl_wp_n), .fl_ready_busy(fl_ready_busy));

  fpes_flash_model model (.clk(clk), .fl_addr(fl_addr), .fl_dq_o(fl_dq_o),
    .fl_ce_n(fl_ce_n), .fl_oe_n(fl_oe_n), .fl_we_n(fl_we_n), .fl_wp_n(fl_wp_n),
    .fl_dq_i(fl_dq_i), .fl_ready_busy(fl_ready_busy), .vpp_low(vpp_low),
    .erase_fail(erase_fail));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : wrap_up

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Request held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] dt);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= dt;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic go(input logic [31:0] ad, input logic [31:0] dt, input logic [2:0] code,
                    input logic [31:0] flags);
    apb(1'b1, FPES_REG_ADDR, ad);
    apb(1'b1, FPES_REG_DATA, dt);
    apb(1'b1, FPES_REG_CTRL, flags | {28'h0, code, 1'b1});
    do apb(1'b0, FPES_REG_STATUS, 32'h0); while (rd[FPES_STS_BUSY] !== 1'b0);
  endtask : go

  // Done and pin high, error summary from flash bits 5,4,3,1
  task automatic st(input logic [7:0] fsr, input string what);
    chk(what, {16'h0, fsr, 8'h12} | (((fsr & 8'h3A) != 8'h0) ? 32'h4 : 32'h0), rd);
  endtask : st

  task automatic arr(input logic [31:0] ad, input logic [15:0] exp);
    go(ad, 32'h0, 3'h5, 32'h0);
    apb(1'b0, FPES_REG_RDATA, 32'h0);
    chk("array word", {16'h0, exp}, rd);
  endtask : arr

  initial begin
    sys_rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    vpp_low = 1'b0;
    clk_en = 1'b1;
    erase_fail = 4'h0;
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    apb(1'b0, FPES_REG_STATUS, 32'h0);
    chk("status after reset", 32'h10, rd);
    apb(1'b0, 12'h040, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, er});
    go(32'h03, 32'h1234, 3'h2, 32'h0); st(8'h80, "program");
    arr(32'h03, 16'h1234);
    go(32'h03, 32'h00FF, 3'h2, 32'h40); st(8'h80, "alt program");
    apb(1'b0, FPES_REG_CTRL, 32'h0);
    chk("control readback", 32'h44, rd);
    arr(32'h03, 16'h0034);
    go(32'h12, 32'h5A5A, 3'h2, 32'h0); st(8'h92, "locked program");
    go(32'h0, 32'h0, 3'h4, 32'h0); st(8'h00, "clear");
    go(32'h12, 32'h5A5A, 3'h2, 32'h20); st(8'h80, "protect high program");
    go(32'h13, 32'h0, 3'h0, 32'h0); st(8'hA2, "locked erase");
    go(32'h0, 32'h0, 3'h4, 32'h0); st(8'h00, "clear");
    go(32'h0, 32'h0, 3'h1, 32'h0); st(8'h80, "chip erase");
    arr(32'h03, 16'hFFFF);
    arr(32'h12, 16'h5A5A);
    apb(1'b1, FPES_REG_COUNT, 32'h3);
    for (int i = 0; i < 4; i++) apb(1'b1, FPES_BUF_BASE + 12'(4 * i), 32'h1100 + i);
    go(32'h05, 32'h0, 3'h3, 32'h0); st(8'h80, "buffered");
    arr(32'h07, 16'h1102);
    apb(1'b0, FPES_REG_COUNT, 32'h0);
    chk("count readback", 32'h3, rd);
    go(32'h0E, 32'h0, 3'h3, 32'h0); st(8'hB0, "boundary");
    arr(32'h0F, 16'h1101);
    arr(32'h10, 16'hFFFF);
    go(32'h05, 32'h0, 3'h3, 32'h0); chk("refused", 32'hA, rd & 32'hA);
    go(32'h0, 32'h0, 3'h4, 32'h0); st(8'h00, "clear");
    apb(1'b1, FPES_REG_COUNT, 32'h10);
    go(32'h05, 32'h0, 3'h3, 32'h0); chk("count limit", 32'hA, rd & 32'hA);
    apb(1'b1, FPES_REG_COUNT, 32'h3);
    apb(1'b1, FPES_REG_ADDR, 32'h13);
    apb(1'b1, FPES_REG_CTRL, 32'h21);
    // Freeze right after start: no strobe or address pin may move while enable is low
    clk_en <= 1'b0;
    @(posedge clk);
    snap = {fl_ce_n, fl_oe_n, fl_we_n, fl_addr};
    repeat (20) @(posedge clk);
    chk("clock enable freeze", {8'h0, snap}, {8'h0, fl_ce_n, fl_oe_n, fl_we_n, fl_addr});
    clk_en <= 1'b1;
    do apb(1'b0, FPES_REG_STATUS, 32'h0); while (rd[FPES_STS_BUSY] !== 1'b0);
    st(8'h80, "block erase");
    arr(32'h12, 16'hFFFF);
    go(32'h33, 32'h0F0F, 3'h2, 32'h0); st(8'h80, "far block program");
    erase_fail <= 4'h4;
    go(32'h0, 32'h0, 3'h1, 32'h20); st(8'hA0, "failing chip erase");
    erase_fail <= 4'h0;
    arr(32'h07, 16'hFFFF);
    arr(32'h33, 16'h0F0F);
    go(32'h0, 32'h0, 3'h4, 32'h0); st(8'h00, "clear");
    vpp_low <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      go(32'h13, 32'h0, 3'(i), 32'h0); st(vexp[i], "supply low");
      go(32'h0, 32'h0, 3'h4, 32'h0);
    end
    wrap_up();
  end

  initial begin
    repeat (60000) @(posedge clk);
    n_fail++;
    wrap_up();
  end
endmodule : fpes_host_bench
